// file: shared/mmc_pkg.sv
package mmc_pkg;

  // Emulation register layout and reset value.
  localparam int unsigned EMU_ENABLE_BIT = 7;
  localparam int unsigned EMU_MOD_BIT    = 6;
  localparam int unsigned EMU_PWR_HI_BIT = 5;
  localparam int unsigned EMU_PWR_LO_BIT = 4;
  localparam int unsigned EMU_DEV_BIT    = 3;
  localparam int unsigned EMU_FREQ_MSB   = 2;
  localparam int unsigned EMU_FREQ_LSB   = 0;
  localparam logic [7:0]  EMU_RESET      = 8'h00;

  // Capacitor field of the first configuration register.
  localparam int unsigned CAP_W     = 5;
  localparam logic [4:0]  CAP_RESET = 5'h00;
  localparam logic [4:0]  CAP_MAX   = 5'h1F;

  // Frequency code that leaves the device under serial-port control.
  localparam logic [2:0]  FREQ_SERIAL = 3'h0;

  // Attenuation below maximum power, in dB.
  localparam logic [3:0]  ATTEN_00 = 4'h0;
  localparam logic [3:0]  ATTEN_01 = 4'h3;
  localparam logic [3:0]  ATTEN_10 = 4'h6;
  localparam logic [3:0]  ATTEN_11 = 4'hA;

  // Half of the FSK deviation, in kHz.
  localparam logic [5:0]  DEV_LOW_KHZ  = 6'h10;
  localparam logic [5:0]  DEV_HIGH_KHZ = 6'h32;

  // Divide ratios scaled by 100000, so 19.68750 reads as 1968750.
  localparam logic [21:0] RATIO_NONE = 22'h000000;
  localparam logic [21:0] RATIO_1    = 22'h1E0A6E;
  localparam logic [21:0] RATIO_2    = 22'h295A6D;
  localparam logic [21:0] RATIO_3    = 22'h25317C;
  localparam logic [21:0] RATIO_4    = 22'h27DD14;
  localparam logic [21:0] RATIO_5    = 22'h237A08;
  localparam logic [21:0] RATIO_6    = 22'h20E6DA;
  localparam logic [21:0] RATIO_7    = 22'h2961C0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_COUNT = 2'b10
  } mmc_prog_e;

  function automatic logic [3:0] mmc_atten(input logic [1:0] sel);
    unique case (sel)
      2'b00:   mmc_atten = ATTEN_00;
      2'b01:   mmc_atten = ATTEN_01;
      2'b10:   mmc_atten = ATTEN_10;
      default: mmc_atten = ATTEN_11;
    endcase
  endfunction : mmc_atten

  function automatic logic [21:0] mmc_ratio(input logic [2:0] code);
    unique case (code)
      3'h1:    mmc_ratio = RATIO_1;
      3'h2:    mmc_ratio = RATIO_2;
      3'h3:    mmc_ratio = RATIO_3;
      3'h4:    mmc_ratio = RATIO_4;
      3'h5:    mmc_ratio = RATIO_5;
      3'h6:    mmc_ratio = RATIO_6;
      3'h7:    mmc_ratio = RATIO_7;
      default: mmc_ratio = RATIO_NONE;
    endcase
  endfunction : mmc_ratio

endpackage : mmc_pkg

// file: core/mmc_config.sv
`timescale 1ns/1ps
module mmc_config (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Manual control pins.
  input  wire logic        freq_select_b0,
  input  wire logic        freq_select_b1,
  input  wire logic        freq_select_b2,
  input  wire logic        mod_select_pin,
  input  wire logic        deviation_select_pin,
  input  wire logic        power_select_hi,
  input  wire logic        power_select_lo,
  input  wire logic        enable_pin,
  input  wire logic        data_in_pin,
  // Register write port from the serial decoder.
  input  wire logic        emu_wr_en,
  input  wire logic [7:0]  emu_wr_data,
  input  wire logic        cap_wr_en,
  input  wire logic [4:0]  cap_wr_data,
  // Register read-back.
  output logic      [7:0]  emu_rd_data,
  output logic      [4:0]  cap_rd_data,
  // Mode status.
  output logic             manual_mode,
  output logic             emu_mode,
  output logic             prog_busy,
  // Effective transmitter settings.
  output logic             mod_fsk,
  output logic      [3:0]  power_atten_db,
  output logic             dev_high,
  output logic      [5:0]  dev_khz,
  output logic      [2:0]  freq_code,
  output logic      [21:0] div_ratio_e5,
  output logic      [4:0]  pa_cap_code,
  // Committed capacitor programming.
  output logic             cap_committed,
  output logic      [4:0]  cap_code_committed,
  output logic      [2:0]  cap_freq_committed
);

  //////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] emu_reg;
  logic [7:0] emu_next;
  logic [4:0] cap_reg;
  logic [4:0] cap_next;

  always_comb begin
    emu_next = emu_reg;
    cap_next = cap_reg;
    if (emu_wr_en) begin
      emu_next = emu_wr_data;
    end
    if (cap_wr_en) begin
      cap_next = cap_wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      emu_reg <= mmc_pkg::EMU_RESET;
      cap_reg <= mmc_pkg::CAP_RESET;
    end else begin
      emu_reg <= emu_next;
      cap_reg <= cap_next;
    end
  end

  assign emu_rd_data = emu_reg;
  assign cap_rd_data = cap_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode and selection between pins and emulation fields.

  logic [2:0] pin_freq;
  logic       pin_manual;
  logic       emu_on;
  logic [2:0] sel_freq;
  logic       sel_mod;
  logic [1:0] sel_pwr;
  logic       sel_dev;

  assign pin_freq   = {freq_select_b2, freq_select_b1, freq_select_b0};
  assign pin_manual = (pin_freq != mmc_pkg::FREQ_SERIAL);
  // Pins win over the register: a high frequency pin forces manual mode.
  assign emu_on     = !pin_manual && emu_reg[mmc_pkg::EMU_ENABLE_BIT];

  always_comb begin
    sel_freq = mmc_pkg::FREQ_SERIAL;
    sel_mod  = 1'b0;
    sel_pwr  = 2'b00;
    sel_dev  = 1'b0;
    if (pin_manual) begin
      sel_freq = pin_freq;
      sel_mod  = mod_select_pin;
      sel_pwr  = {power_select_hi, power_select_lo};
      sel_dev  = deviation_select_pin;
    end else if (emu_on) begin
      sel_freq = emu_reg[mmc_pkg::EMU_FREQ_MSB:mmc_pkg::EMU_FREQ_LSB];
      sel_mod  = emu_reg[mmc_pkg::EMU_MOD_BIT];
      sel_pwr  = {emu_reg[mmc_pkg::EMU_PWR_HI_BIT],
                  emu_reg[mmc_pkg::EMU_PWR_LO_BIT]};
      sel_dev  = emu_reg[mmc_pkg::EMU_DEV_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capacitor programming sequence.

  mmc_pkg::mmc_prog_e st_reg;
  mmc_pkg::mmc_prog_e st_next;
  logic       din_prev_reg;
  logic       en_prev_reg;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic [2:0] cfreq_reg;
  logic [2:0] cfreq_next;
  logic       valid_reg;
  logic       valid_next;
  logic [4:0] cval_reg;
  logic [4:0] cval_next;
  logic [2:0] cfc_reg;
  logic [2:0] cfc_next;
  logic       din_rise;
  logic       en_rise;

  assign din_rise = data_in_pin && !din_prev_reg;
  assign en_rise  = enable_pin && !en_prev_reg;

  always_comb begin
    st_next    = st_reg;
    count_next = count_reg;
    cfreq_next = cfreq_reg;
    valid_next = valid_reg;
    cval_next  = cval_reg;
    cfc_next   = cfc_reg;
    unique case (st_reg)
      mmc_pkg::ST_IDLE: begin
        // Pulses while enable is high are ignored.
        if (din_rise && !enable_pin) begin
          st_next    = mmc_pkg::ST_COUNT;
          count_next = 5'h00;
          cfreq_next = sel_freq;
        end
      end
      mmc_pkg::ST_COUNT: begin
        if (en_rise) begin
          st_next    = mmc_pkg::ST_IDLE;
          valid_next = 1'b1;
          cval_next  = count_reg;
          cfc_next   = cfreq_reg;
        end else if (din_rise && !enable_pin && count_reg != mmc_pkg::CAP_MAX) begin
          // Saturates at the top code; a 33rd pulse cannot wrap to zero.
          count_next = count_reg + 5'h01;
        end
      end
      default: begin
        st_next = mmc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg       <= mmc_pkg::ST_IDLE;
      din_prev_reg <= 1'b0;
      en_prev_reg  <= 1'b0;
      count_reg    <= mmc_pkg::CAP_RESET;
      cfreq_reg    <= mmc_pkg::FREQ_SERIAL;
      valid_reg    <= 1'b0;
      cval_reg     <= mmc_pkg::CAP_RESET;
      cfc_reg      <= mmc_pkg::FREQ_SERIAL;
    end else begin
      st_reg       <= st_next;
      din_prev_reg <= data_in_pin;
      en_prev_reg  <= enable_pin;
      count_reg    <= count_next;
      cfreq_reg    <= cfreq_next;
      valid_reg    <= valid_next;
      cval_reg     <= cval_next;
      cfc_reg      <= cfc_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered effective settings.

  logic        manual_next;
  logic        emu_mode_next;
  logic        mod_next;
  logic [3:0]  atten_next;
  logic        dev_next;
  logic [5:0]  devk_next;
  logic [2:0]  freq_next;
  logic [21:0] ratio_next;
  logic [4:0]  pacap_next;

  always_comb begin
    manual_next   = pin_manual;
    emu_mode_next = emu_on;
    mod_next      = sel_mod;
    atten_next    = mmc_pkg::mmc_atten(sel_pwr);
    dev_next      = sel_dev;
    devk_next     = sel_dev ? mmc_pkg::DEV_HIGH_KHZ : mmc_pkg::DEV_LOW_KHZ;
    freq_next     = sel_freq;
    ratio_next    = mmc_pkg::mmc_ratio(sel_freq);
    pacap_next    = 5'h00;
    if (!pin_manual && cap_reg != 5'h00) begin
      pacap_next = cap_reg;
    end else if ((pin_manual || emu_on) && valid_reg && sel_freq == cfc_reg) begin
      pacap_next = cval_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      manual_mode    <= 1'b0;
      emu_mode       <= 1'b0;
      mod_fsk        <= 1'b0;
      power_atten_db <= mmc_pkg::ATTEN_00;
      dev_high       <= 1'b0;
      dev_khz        <= mmc_pkg::DEV_LOW_KHZ;
      freq_code      <= mmc_pkg::FREQ_SERIAL;
      div_ratio_e5   <= mmc_pkg::RATIO_NONE;
      pa_cap_code    <= mmc_pkg::CAP_RESET;
    end else begin
      manual_mode    <= manual_next;
      emu_mode       <= emu_mode_next;
      mod_fsk        <= mod_next;
      power_atten_db <= atten_next;
      dev_high       <= dev_next;
      dev_khz        <= devk_next;
      freq_code      <= freq_next;
      div_ratio_e5   <= ratio_next;
      pa_cap_code    <= pacap_next;
    end
  end

  assign prog_busy          = (st_reg == mmc_pkg::ST_COUNT);
  assign cap_committed      = valid_reg;
  assign cap_code_committed = cval_reg;
  assign cap_freq_committed = cfc_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_power_map_six: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pin_manual && power_select_hi && !power_select_lo) |=> (power_atten_db == 4'h6))
    else $error("power select 10 did not give 6 dB");

  a_dev_map_high: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pin_manual && deviation_select_pin) |=> (dev_high && dev_khz == 6'h32))
    else $error("high deviation select did not give 50 kHz");

  a_first_pulse_capture: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg == mmc_pkg::ST_IDLE && data_in_pin && !din_prev_reg && !enable_pin)
    |=> (prog_busy && count_reg == 5'h00 && cfreq_reg == $past(sel_freq)))
    else $error("first pulse did not clear counter and capture frequency");

  a_freq_held_counting: assert property (@(posedge ref_clk) disable iff (!resetn)
    (prog_busy && $past(prog_busy)) |-> $stable(cfreq_reg))
    else $error("captured frequency changed after the first pulse");

  a_pulse_increment: assert property (@(posedge ref_clk) disable iff (!resetn)
    (prog_busy && din_rise && !enable_pin && !en_rise && count_reg < 5'h1F)
    |=> (count_reg == $past(count_reg) + 5'h01))
    else $error("later pulse did not increment the capacitor code");

  a_enable_commit: assert property (@(posedge ref_clk) disable iff (!resetn)
    (prog_busy && enable_pin && !en_prev_reg)
    |=> (cap_committed && !prog_busy && cap_code_committed == $past(count_reg)
         && cap_freq_committed == $past(cfreq_reg)))
    else $error("enable rise did not commit the counted code");

  a_cap_other_freq: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pin_manual && pin_freq != cfc_reg) |=> (pa_cap_code == 5'h00))
    else $error("capacitance added at a frequency not programmed");

  a_cap_own_freq: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pin_manual && valid_reg && pin_freq == cfc_reg) |=> (pa_cap_code == $past(cval_reg)))
    else $error("programmed capacitance missing at its frequency");

  a_emu_enable_fields: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!pin_manual && emu_reg[7])
    |=> (emu_mode && mod_fsk == $past(emu_reg[6]) && dev_high == $past(emu_reg[3])))
    else $error("emulation fields did not replace the pins");

  a_emu_power_freq: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!pin_manual && emu_reg[7])
    |=> (power_atten_db == mmc_pkg::mmc_atten($past(emu_reg[5:4]))
         && freq_code == $past(emu_reg[2:0])))
    else $error("emulation power or frequency field not applied");

  a_reg_cap_override: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!pin_manual && cap_reg != 5'h00) |=> (pa_cap_code == $past(cap_reg)))
    else $error("nonzero register capacitor did not override pulses");

  a_manual_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
    (freq_select_b0 || freq_select_b1 || freq_select_b2) |=> (manual_mode && !emu_mode))
    else $error("frequency pin high did not select manual mode");

  a_ratio_serial: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!pin_manual && !emu_reg[7]) |=> (div_ratio_e5 == 22'h000000 && freq_code == 3'h0))
    else $error("serial mode produced a manual divide ratio");

  a_enable_high_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (enable_pin && !en_rise) |=> ($stable(count_reg) && $stable(cfreq_reg)))
    else $error("pulse with enable high altered the counter");

endmodule : mmc_config

// file: tb/mmc_ctrl_model.sv
`timescale 1ns/1ps
module mmc_ctrl_model (
  // Clock.
  input  wire logic ref_clk,
  // Control pins driven towards the device.
  output logic      freq_select_b0,
  output logic      freq_select_b1,
  output logic      freq_select_b2,
  output logic      enable_pin,
  output logic      data_in_pin
);
  // Enable starts high, so the device sees an enable rise with no sequence at reset release.
  initial begin
    {freq_select_b2, freq_select_b1, freq_select_b0} = 3'h0;
    enable_pin = 1'b1;
    data_in_pin = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic set_freq(input logic [2:0] f);
    @(posedge ref_clk);
    {freq_select_b2, freq_select_b1, freq_select_b0} <= f;
    @(posedge ref_clk);
  endtask : set_freq

  // Each pulse is two cycles high and two low; the code may move after the first one.
  task automatic send_pulses(input int n, input logic [2:0] f_after);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      data_in_pin <= 1'b1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      data_in_pin <= 1'b0;
      if (i == 0) begin
        {freq_select_b2, freq_select_b1, freq_select_b0} <= f_after;
      end
      @(posedge ref_clk);
    end
  endtask : send_pulses

  // One call is one whole sequence; a later call replaces the value an earlier one set.
  task automatic prog_sequence(input logic [2:0] f, input int n, input logic [2:0] f_after);
    @(posedge ref_clk);
    enable_pin <= 1'b0;
    set_freq(f);
    repeat (2) @(posedge ref_clk);
    send_pulses(n, f_after);
    @(posedge ref_clk);
    enable_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : prog_sequence
endmodule : mmc_ctrl_model

// file: tb/test_manual_mode_config_logic.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); \
  end \
end
module test_manual_mode_config_logic;
  logic        ref_clk, resetn, mod_select_pin, deviation_select_pin;
  logic        power_select_hi, power_select_lo, emu_wr_en, cap_wr_en;
  logic        manual_mode, emu_mode, prog_busy, mod_fsk, dev_high, cap_committed;
  logic        f0, f1, f2, enable_pin, data_in_pin;
  logic [7:0]  emu_wr_data, emu_rd_data;
  logic [4:0]  cap_wr_data, cap_rd_data, pa_cap_code, cap_code_committed;
  logic [3:0]  power_atten_db;
  logic [5:0]  dev_khz;
  logic [2:0]  freq_code, cap_freq_committed;
  logic [21:0] div_ratio_e5;
  logic [3:0]  atten_tbl [4] = '{4'h0, 4'h3, 4'h6, 4'hA};
  logic [21:0] ratio_tbl [8] = '{22'h000000, 22'h1E0A6E, 22'h295A6D, 22'h25317C,
                                 22'h27DD14, 22'h237A08, 22'h20E6DA, 22'h2961C0};
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;

  mmc_ctrl_model u_ctrl (.ref_clk(ref_clk), .freq_select_b0(f0), .freq_select_b1(f1),
    .freq_select_b2(f2), .enable_pin(enable_pin), .data_in_pin(data_in_pin));

  mmc_config dut (.ref_clk(ref_clk), .resetn(resetn), .freq_select_b0(f0),
    .freq_select_b1(f1), .freq_select_b2(f2), .mod_select_pin(mod_select_pin),
    .deviation_select_pin(deviation_select_pin), .power_select_hi(power_select_hi),
    .power_select_lo(power_select_lo), .enable_pin(enable_pin), .data_in_pin(data_in_pin),
    .emu_wr_en(emu_wr_en), .emu_wr_data(emu_wr_data), .cap_wr_en(cap_wr_en),
    .cap_wr_data(cap_wr_data), .emu_rd_data(emu_rd_data), .cap_rd_data(cap_rd_data),
    .manual_mode(manual_mode), .emu_mode(emu_mode), .prog_busy(prog_busy),
    .mod_fsk(mod_fsk), .power_atten_db(power_atten_db), .dev_high(dev_high),
    .dev_khz(dev_khz), .freq_code(freq_code), .div_ratio_e5(div_ratio_e5),
    .pa_cap_code(pa_cap_code), .cap_committed(cap_committed),
    .cap_code_committed(cap_code_committed), .cap_freq_committed(cap_freq_committed));

  always #2.5 ref_clk = ~ref_clk;

  // A hang is cut short far beyond the few hundred cycles the run needs.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic wr_reg(input logic is_cap, input logic [7:0] v);
    @(posedge ref_clk);
    emu_wr_en <= !is_cap;
    cap_wr_en <= is_cap;
    emu_wr_data <= v;
    cap_wr_data <= v[4:0];
    @(posedge ref_clk);
    emu_wr_en <= 1'b0;
    cap_wr_en <= 1'b0;
    settle(2);
  endtask : wr_reg

  task automatic chk_set(input logic [2:0] f, input logic m, input logic [1:0] p, input logic d);
    `CHK(freq_code, f);
    `CHK(div_ratio_e5, ratio_tbl[f]);
    `CHK(mod_fsk, m);
    `CHK(power_atten_db, atten_tbl[p]);
    `CHK(dev_high, d);
    `CHK(dev_khz, d ? 6'h32 : 6'h10);
  endtask : chk_set

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    settle(1);
    `CHK(emu_rd_data, 8'h00);
    `CHK(cap_rd_data, 5'h00);
    `CHK(manual_mode, 1'b0);
    `CHK(cap_committed, 1'b0);
  endtask : t_reset

  task automatic t_emu();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {1'b1, i[2], i[1:0], ~i[0], i[2:0]};
      wr_reg(1'b0, v);
      `CHK(emu_rd_data, v);
      `CHK(emu_mode, 1'b1);
      chk_set(i[2:0], i[2], i[1:0], ~i[0]);
    end
    wr_reg(1'b0, 8'h7F);
    `CHK(emu_mode, 1'b0);
  endtask : t_emu

  task automatic t_manual();
    wr_reg(1'b0, 8'hFF);
    for (int i = 1; i < 8; i++) begin
      @(posedge ref_clk);
      mod_select_pin <= ~i[0];
      {power_select_hi, power_select_lo} <= i[1:0];
      deviation_select_pin <= i[2];
      u_ctrl.set_freq(i[2:0]);
      settle(2);
      `CHK(manual_mode, 1'b1);
      `CHK(emu_mode, 1'b0);
      chk_set(i[2:0], ~i[0], i[1:0], i[2]);
    end
  endtask : t_manual

  task automatic t_prog();
    u_ctrl.prog_sequence(3'h1, 11, 3'h7);
    settle(1);
    `CHK(cap_committed, 1'b1);
    `CHK(cap_code_committed, 5'h0A);
    `CHK(cap_freq_committed, 3'h1);
    `CHK(prog_busy, 1'b0);
    `CHK(pa_cap_code, 5'h00);
    u_ctrl.set_freq(3'h1);
    settle(2);
    `CHK(pa_cap_code, 5'h0A);
    u_ctrl.send_pulses(3, 3'h1);
    settle(2);
    `CHK(cap_code_committed, 5'h0A);
    `CHK(prog_busy, 1'b0);
  endtask : t_prog

  task automatic t_bounds();
    u_ctrl.prog_sequence(3'h4, 32, 3'h4);
    settle(2);
    `CHK(cap_code_committed, 5'h1F);
    `CHK(pa_cap_code, 5'h1F);
    u_ctrl.prog_sequence(3'h2, 1, 3'h2);
    settle(2);
    `CHK(cap_code_committed, 5'h00);
    `CHK(cap_freq_committed, 3'h2);
  endtask : t_bounds

  task automatic t_emu_cap();
    u_ctrl.set_freq(3'h0);
    wr_reg(1'b0, 8'h83);
    u_ctrl.prog_sequence(3'h0, 6, 3'h0);
    settle(2);
    `CHK(cap_freq_committed, 3'h3);
    `CHK(pa_cap_code, 5'h05);
    wr_reg(1'b1, 8'h09);
    `CHK(cap_rd_data, 5'h09);
    `CHK(pa_cap_code, 5'h09);
    wr_reg(1'b1, 8'h00);
    `CHK(pa_cap_code, 5'h05);
  endtask : t_emu_cap

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    {mod_select_pin, deviation_select_pin, power_select_hi, power_select_lo} = 4'h0;
    {emu_wr_en, cap_wr_en} = 2'b00;
    emu_wr_data = 8'h00;
    cap_wr_data = 5'h00;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_emu();
    t_manual();
    t_prog();
    t_bounds();
    t_emu_cap();
    finish_test();
  end
endmodule : test_manual_mode_config_logic
